// ===== hdl/cbm_cfg.svh
// Constants for the code bank mapper: addresses, fields, reset values and sizes.
`ifndef CBM_CFG_SVH
`define CBM_CFG_SVH

`define CBM_CODE_AW          16
`define CBM_PHYS_AW          17
`define CBM_BANK_OFS_AW      15
`define CBM_UPPER_BIT        15
`define CBM_BANK_W           2
`define CBM_BYTE_W           8
`define CBM_SFR_AW           8

`define CBM_BANK_SELECT_ADDR 8'hB1
`define CBM_STORE_CTRL_ADDR  8'hB2
`define CBM_BANK_SELECT_RST  8'h00
`define CBM_STORE_CTRL_RST   8'h00
`define CBM_BANK_SELECT_MASK 8'h33
`define CBM_STORE_CTRL_MASK  8'h01

`define CBM_CONST_BANK_HI    5
`define CBM_CONST_BANK_LO    4
`define CBM_FETCH_BANK_HI    1
`define CBM_FETCH_BANK_LO    0
`define CBM_STORE_WE_BIT     0

`define CBM_BANK_ZERO        2'h0
`define CBM_RESERVED_BASE    17'h1_FC00
`define CBM_SMALL_TOP_BIT    1'h0

`define CBM_RAM_DEPTH        256
`define CBM_RAM_AW           8

`define CBM_ZERO_BYTE        8'h00
`define CBM_ZERO_CODE        16'h0000
`define CBM_ZERO_PHYS        17'h0_0000

`endif

// ===== hdl/cbm_pkg.sv
// Types shared by the code bank mapper files.
`include "cbm_cfg.svh"
package cbm_pkg;
  typedef logic [`CBM_BANK_W-1:0] cbm_bank_t;
  typedef logic [`CBM_PHYS_AW-1:0] cbm_phys_t;
  typedef enum logic [1:0] {
    CBM_KIND_NONE     = 2'h0,
    CBM_KIND_FETCH    = 2'h1,
    CBM_KIND_CONST_RD = 2'h2,
    CBM_KIND_FLASH_WR = 2'h3
  } cbm_kind_t;
endpackage : cbm_pkg

// ===== hdl/cbm_data_ram.sv
// Internal data memory of 256 bytes with registered read data.
`timescale 1ns/1ps
`default_nettype none
`include "cbm_cfg.svh"
module cbm_data_ram (
  input  wire logic                     i_sys_clk,
  input  wire logic                     i_req,
  input  wire logic                     i_we,
  input  wire logic [`CBM_RAM_AW-1:0]   i_addr,
  input  wire logic [`CBM_BYTE_W-1:0]   i_wdata,
  output var  logic [`CBM_BYTE_W-1:0]   o_rdata
);
  logic [`CBM_BYTE_W-1:0] mem [0:`CBM_RAM_DEPTH-1];

  always_ff @(posedge i_sys_clk) begin
    if (i_req && i_we) begin
      mem[i_addr] <= i_wdata;
    end
  end

  // Read returns the old byte on a same-cycle write, like a plain synchronous RAM.
  always_ff @(posedge i_sys_clk) begin
    if (i_req) begin
      o_rdata <= mem[i_addr];
    end
  end
endmodule : cbm_data_ram
`default_nettype wire

// ===== hdl/cbm_bank_regs.sv
// Bank select and program store control registers on the special function bus.
`timescale 1ns/1ps
`default_nettype none
`include "cbm_cfg.svh"
module cbm_bank_regs
  import cbm_pkg::*;
(
  input  wire logic                     i_sys_clk,
  input  wire logic                     i_rst,
  input  wire logic                     i_sfr_rd,
  input  wire logic                     i_sfr_wr,
  input  wire logic [`CBM_SFR_AW-1:0]   i_sfr_addr,
  input  wire logic [`CBM_BYTE_W-1:0]   i_sfr_wdata,
  output var  logic [`CBM_BYTE_W-1:0]   o_sfr_rdata,
  output var  logic                     o_sfr_ack,
  output var  cbm_pkg::cbm_bank_t       o_fetch_bank,
  output var  cbm_pkg::cbm_bank_t       o_const_bank,
  output var  logic                     o_store_we
);
  import cbm_pkg::*;
  logic [`CBM_BYTE_W-1:0] bank_select;
  logic [`CBM_BYTE_W-1:0] store_control;
  logic                   hit_bank;
  logic                   hit_ctrl;

  assign hit_bank = (i_sfr_addr == `CBM_BANK_SELECT_ADDR);
  assign hit_ctrl = (i_sfr_addr == `CBM_STORE_CTRL_ADDR);

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      bank_select <= `CBM_BANK_SELECT_RST;
    end else if (i_sfr_wr && hit_bank) begin
      bank_select <= i_sfr_wdata & `CBM_BANK_SELECT_MASK;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      store_control <= `CBM_STORE_CTRL_RST;
    end else if (i_sfr_wr && hit_ctrl) begin
      store_control <= i_sfr_wdata & `CBM_STORE_CTRL_MASK;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_sfr_rdata <= `CBM_ZERO_BYTE;
      o_sfr_ack   <= 1'b0;
    end else begin
      o_sfr_ack <= (i_sfr_rd || i_sfr_wr) && (hit_bank || hit_ctrl);
      if (i_sfr_rd && hit_bank) begin
        o_sfr_rdata <= bank_select;
      end else if (i_sfr_rd && hit_ctrl) begin
        o_sfr_rdata <= store_control;
      end else begin
        o_sfr_rdata <= `CBM_ZERO_BYTE;
      end
    end
  end

  assign o_const_bank = bank_select[`CBM_CONST_BANK_HI:`CBM_CONST_BANK_LO];
  assign o_fetch_bank = bank_select[`CBM_FETCH_BANK_HI:`CBM_FETCH_BANK_LO];
  assign o_store_we   = store_control[`CBM_STORE_WE_BIT];
endmodule : cbm_bank_regs
`default_nettype wire

// ===== hdl/cbm_mapper.sv
// Top of the code bank mapper: address translation for fetch, constant and move paths.
`timescale 1ns/1ps
`default_nettype none
`include "cbm_cfg.svh"

// What this block does
// - Four 32 kB banks behind 16-bit space.
// - Lower half always maps bank zero.
// - One upper bank fills the upper half.
// - Upper fetches use the fetch bank.
// - Upper constant access uses constant bank field.
// - Bank code zero mirrors the lower half.
// - Fetch bank held in bits one-zero.
// - Top 1024 bytes of bank three reserved.
// - Small variant: flat 64 kB, no banking.
// - Write enable steers move writes to flash.
// - Program and data spaces kept separate.
// - 256 bytes internal data memory.
module cbm_mapper
  import cbm_pkg::*;
(
  input  wire logic                     i_sys_clk,
  input  wire logic                     i_rst,
  input  wire logic                     i_small_variant,
  input  wire logic                     i_sfr_rd,
  input  wire logic                     i_sfr_wr,
  input  wire logic [`CBM_SFR_AW-1:0]   i_sfr_addr,
  input  wire logic [`CBM_BYTE_W-1:0]   i_sfr_wdata,
  output var  logic [`CBM_BYTE_W-1:0]   o_sfr_rdata,
  output var  logic                     o_sfr_ack,
  input  wire logic                     i_fetch_req,
  input  wire logic [`CBM_CODE_AW-1:0]  i_fetch_addr,
  output var  logic                     o_fetch_valid,
  output var  cbm_pkg::cbm_phys_t       o_fetch_phys,
  input  wire logic                     i_code_rd_req,
  input  wire logic [`CBM_CODE_AW-1:0]  i_code_rd_addr,
  input  wire logic                     i_xmove_req,
  input  wire logic                     i_xmove_we,
  input  wire logic [`CBM_CODE_AW-1:0]  i_xmove_addr,
  input  wire logic [`CBM_BYTE_W-1:0]   i_xmove_wdata,
  output var  logic                     o_const_valid,
  output var  logic                     o_const_we,
  output var  cbm_pkg::cbm_phys_t       o_const_phys,
  output var  logic [`CBM_BYTE_W-1:0]   o_const_wdata,
  output var  logic                     o_xdata_valid,
  output var  logic                     o_xdata_we,
  output var  logic [`CBM_CODE_AW-1:0]  o_xdata_addr,
  output var  logic [`CBM_BYTE_W-1:0]   o_xdata_wdata,
  output var  logic                     o_reserved_hit,
  output var  cbm_pkg::cbm_kind_t       o_last_kind,
  input  wire logic                     i_idata_req,
  input  wire logic                     i_idata_we,
  input  wire logic [`CBM_RAM_AW-1:0]   i_idata_addr,
  input  wire logic [`CBM_BYTE_W-1:0]   i_idata_wdata,
  output var  logic [`CBM_BYTE_W-1:0]   o_idata_rdata,
  output var  logic                     o_idata_valid
);
  import cbm_pkg::*;

  // Bank fields, strap stages and the next values of the output registers.
  cbm_bank_t              fetch_bank;
  cbm_bank_t              const_bank;
  logic                   store_we;
  logic                   small_meta;
  logic                   small_sync;
  cbm_phys_t              next_fetch_phys;
  cbm_phys_t              next_const_phys;
  logic [`CBM_CODE_AW-1:0] const_addr;
  logic                   move_to_flash;
  logic                   const_go;
  logic                   next_reserved;
  cbm_kind_t              next_last_kind;

  // Register bank: bank select and program store control.
  cbm_bank_regs u_bank_regs (
    .i_sys_clk   (i_sys_clk),
    .i_rst       (i_rst),
    .i_sfr_rd    (i_sfr_rd),
    .i_sfr_wr    (i_sfr_wr),
    .i_sfr_addr  (i_sfr_addr),
    .i_sfr_wdata (i_sfr_wdata),
    .o_sfr_rdata (o_sfr_rdata),
    .o_sfr_ack   (o_sfr_ack),
    .o_fetch_bank(fetch_bank),
    .o_const_bank(const_bank),
    .o_store_we  (store_we)
  );

  // The variant strap is a pin, so it passes two flip-flops before use.
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      small_meta <= 1'b0;
    end else begin
      small_meta <= i_small_variant;
    end
  end

  // Only this second stage is read, so a metastable first stage never leaks out.
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      small_sync <= 1'b0;
    end else begin
      small_sync <= small_meta;
    end
  end

  // Code address to physical flash address for a given upper bank.
  function automatic cbm_phys_t cbm_translate(
    input logic [`CBM_CODE_AW-1:0] addr,
    input cbm_bank_t               bank,
    input logic                    is_small
  );
    cbm_phys_t phys;
    phys = `CBM_ZERO_PHYS;
    if (is_small) begin
      // The small part has no bank bits, so the top address bit is tied low.
      // Flat small variant.
      phys = {`CBM_SMALL_TOP_BIT, addr};
    end else if (addr[`CBM_UPPER_BIT]) begin
      phys = {bank, addr[`CBM_BANK_OFS_AW-1:0]};
    end else begin
      phys = {`CBM_BANK_ZERO, addr[`CBM_BANK_OFS_AW-1:0]};
    end
    return phys;
  endfunction : cbm_translate

  // Two bank bits over a 15-bit offset.
  assign next_fetch_phys = cbm_translate(i_fetch_addr, fetch_bank, small_sync);

  // A move read never goes to flash, whatever the enable says.
  // Writes go to flash only while enabled.
  assign move_to_flash = i_xmove_req && i_xmove_we && store_we;

  // A flash write wins over a code read issued in the same cycle; the core never does both.
  always_comb begin
    const_addr = i_code_rd_addr;
    const_go   = i_code_rd_req;
    // Code reads keep their own address unless a flash write takes the path.
    if (move_to_flash) begin
      const_addr = i_xmove_addr;
      const_go   = 1'b1;
    end
  end

  // Constant path uses its own bank.
  assign next_const_phys = cbm_translate(const_addr, const_bank, small_sync);

  always_comb begin
    // Only the constant path is checked against the top of bank three; fetches there are not flagged.
    next_reserved = 1'b0;
    if (!small_sync && const_go) begin
      next_reserved = (next_const_phys >= `CBM_RESERVED_BASE);
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_fetch_valid <= 1'b0;
    end else begin
      o_fetch_valid <= i_fetch_req;
    end
  end

  // The translated address holds between fetches, so the core may read it late.
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_fetch_phys <= `CBM_ZERO_PHYS;
    end else if (i_fetch_req) begin
      o_fetch_phys <= next_fetch_phys;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_const_valid <= 1'b0;
    end else begin
      o_const_valid <= const_go && !(move_to_flash && next_reserved);
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_const_we <= 1'b0;
    end else begin
      o_const_we <= move_to_flash && !next_reserved;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_const_phys <= `CBM_ZERO_PHYS;
    end else if (const_go) begin
      o_const_phys <= next_const_phys;
    end
  end

  // Write data holds after the strobe so the flash side may latch it late.
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_const_wdata <= `CBM_ZERO_BYTE;
    end else if (move_to_flash) begin
      o_const_wdata <= i_xmove_wdata;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_xdata_valid <= 1'b0;
    end else begin
      o_xdata_valid <= i_xmove_req && !move_to_flash;
    end
  end

  // Flash writes leave data memory alone.
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_xdata_we <= 1'b0;
    end else begin
      o_xdata_we <= i_xmove_req && i_xmove_we && !store_we;
    end
  end

  // Address and data hold from the last data move.
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_xdata_addr <= `CBM_ZERO_CODE;
    end else if (i_xmove_req && !move_to_flash) begin
      o_xdata_addr <= i_xmove_addr;
    end
  end

  // Write data follows the same hold rule as the address.
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_xdata_wdata <= `CBM_ZERO_BYTE;
    end else if (i_xmove_req && !move_to_flash) begin
      o_xdata_wdata <= i_xmove_wdata;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_reserved_hit <= 1'b0;
    end else begin
      o_reserved_hit <= next_reserved;
    end
  end

  // Software visibility of which path last touched program memory.
  always_comb begin
    next_last_kind = o_last_kind;
    if (move_to_flash) begin
      next_last_kind = CBM_KIND_FLASH_WR;
    end else if (i_code_rd_req) begin
      next_last_kind = CBM_KIND_CONST_RD;
    end else if (i_fetch_req) begin
      next_last_kind = CBM_KIND_FETCH;
    end
  end

  // Flash writes outrank code reads, which outrank fetches.
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_last_kind <= CBM_KIND_NONE;
    end else begin
      o_last_kind <= next_last_kind;
    end
  end

  cbm_data_ram u_data_ram (
    .i_sys_clk(i_sys_clk),
    .i_req    (i_idata_req),
    .i_we     (i_idata_we),
    .i_addr   (i_idata_addr),
    .i_wdata  (i_idata_wdata),
    .o_rdata  (o_idata_rdata)
  );

  // Reads are answered one cycle later, from the memory's own output register.
  // Read answer strobe.
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_idata_valid <= 1'b0;
    end else begin
      o_idata_valid <= i_idata_req && !i_idata_we;
    end
  end
endmodule : cbm_mapper
`default_nettype wire

// ===== sim/cbm_mapper_asserts.sv
// Port checker for the code bank mapper.
`timescale 1ns/1ps
`default_nettype none
`include "cbm_cfg.svh"
module cbm_mapper_chk (
  input wire logic                    i_sys_clk,
  input wire logic                    i_rst,
  input wire logic                    i_sfr_rd,
  input wire logic                    i_sfr_wr,
  input wire logic [`CBM_SFR_AW-1:0]  i_sfr_addr,
  input wire logic [`CBM_BYTE_W-1:0]  o_sfr_rdata,
  input wire logic                    o_sfr_ack,
  input wire logic                    i_fetch_req,
  input wire logic [`CBM_CODE_AW-1:0] i_fetch_addr,
  input wire logic                    o_fetch_valid,
  input wire cbm_pkg::cbm_phys_t      o_fetch_phys,
  input wire logic                    i_code_rd_req,
  input wire logic                    i_xmove_req,
  input wire logic                    i_xmove_we,
  input wire logic [`CBM_CODE_AW-1:0] i_xmove_addr,
  input wire logic                    o_const_valid,
  input wire logic                    o_const_we,
  input wire logic                    o_xdata_valid,
  input wire logic [`CBM_CODE_AW-1:0] o_xdata_addr,
  input wire logic                    o_reserved_hit,
  input wire logic                    i_idata_req,
  input wire logic                    i_idata_we,
  input wire logic                    o_idata_valid
);
  import cbm_pkg::*;
  wire logic mapped = (i_sfr_addr == `CBM_BANK_SELECT_ADDR) || (i_sfr_addr == `CBM_STORE_CTRL_ADDR);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  a_fetch_answer: assert property (i_fetch_req |=> o_fetch_valid)
    else $error("fetch not answered");
  a_fetch_quiet: assert property (!i_fetch_req |=> !o_fetch_valid)
    else $error("fetch valid without request");
  a_lower_bank_zero: assert property (i_fetch_req && !i_fetch_addr[15] |=>
    o_fetch_phys == {2'h0, $past(i_fetch_addr[14:0])}) else $error("lower half not bank zero");
  a_sfr_ack: assert property ((i_sfr_rd || i_sfr_wr) && mapped |=> o_sfr_ack)
    else $error("register access not acknowledged");
  a_sfr_refuse: assert property (!((i_sfr_rd || i_sfr_wr) && mapped) |=>
    !o_sfr_ack && o_sfr_rdata == 8'h00) else $error("unmapped access answered");
  a_code_read: assert property (i_code_rd_req && !(i_xmove_req && i_xmove_we) |=>
    o_const_valid && !o_const_we) else $error("code read not answered");
  a_reserved_block: assert property (o_reserved_hit |-> !o_const_we)
    else $error("write reached reserved flash");
  a_move_write_split: assert property (i_xmove_req && i_xmove_we |=>
    o_xdata_valid ^ (o_const_we || o_reserved_hit)) else $error("move write not steered");
  a_xdata_read: assert property (i_xmove_req && !i_xmove_we |=>
    o_xdata_valid && o_xdata_addr == $past(i_xmove_addr)) else $error("move read lost");
  a_idata_read: assert property (i_idata_req && !i_idata_we |=> o_idata_valid)
    else $error("data memory read not answered");
endmodule : cbm_mapper_chk
bind cbm_mapper cbm_mapper_chk u_chk (.i_sys_clk, .i_rst, .i_sfr_rd, .i_sfr_wr, .i_sfr_addr,
  .o_sfr_rdata, .o_sfr_ack, .i_fetch_req, .i_fetch_addr, .o_fetch_valid, .o_fetch_phys,
  .i_code_rd_req, .i_xmove_req, .i_xmove_we, .i_xmove_addr, .o_const_valid, .o_const_we,
  .o_xdata_valid, .o_xdata_addr, .o_reserved_hit, .i_idata_req, .i_idata_we, .o_idata_valid);
`default_nettype wire

// ===== sim/cbm_core_model.sv
// Core model issuing fetch, code read and move requests.
`timescale 1ns/1ps
`default_nettype none
`include "cbm_cfg.svh"
module cbm_core_model (
  input  wire logic                    i_sys_clk,
  output var  logic                    o_fetch_req,
  output var  logic [`CBM_CODE_AW-1:0] o_fetch_addr,
  output var  logic                    o_code_rd_req,
  output var  logic [`CBM_CODE_AW-1:0] o_code_rd_addr,
  output var  logic                    o_xmove_req,
  output var  logic                    o_xmove_we,
  output var  logic [`CBM_CODE_AW-1:0] o_xmove_addr,
  output var  logic [`CBM_BYTE_W-1:0]  o_xmove_wdata
);
  initial begin
    o_fetch_req = 1'h0;
    o_fetch_addr = 16'h0000;
    o_code_rd_req = 1'h0;
    o_code_rd_addr = 16'h0000;
    o_xmove_req = 1'h0;
    o_xmove_we = 1'h0;
    o_xmove_addr = 16'h0000;
    o_xmove_wdata = 8'h00;
  end
  // Fetch by instruction.
  // Released lines go to the inverse, so a stale address can never pass as held.
  task automatic fetch(input logic [15:0] a);
    @(posedge i_sys_clk);
    o_fetch_req  <= 1'h1;
    o_fetch_addr <= a;
    @(posedge i_sys_clk);
    o_fetch_req  <= 1'h0;
    o_fetch_addr <= ~a;
    #1;
  endtask : fetch
  task automatic code_rd(input logic [15:0] a);
    @(posedge i_sys_clk);
    o_code_rd_req  <= 1'h1;
    o_code_rd_addr <= a;
    @(posedge i_sys_clk);
    o_code_rd_req  <= 1'h0;
    o_code_rd_addr <= ~a;
    #1;
  endtask : code_rd
  task automatic xmove(input logic we, input logic [15:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    o_xmove_req   <= 1'h1;
    o_xmove_we    <= we;
    o_xmove_addr  <= a;
    o_xmove_wdata <= d;
    @(posedge i_sys_clk);
    o_xmove_req   <= 1'h0;
    o_xmove_we    <= ~we;
    o_xmove_addr  <= ~a;
    o_xmove_wdata <= ~d;
    #1;
  endtask : xmove
endmodule : cbm_core_model
`default_nettype wire

// ===== sim/tb_code_bank_mapper.sv
// Self-checking bench for the code bank mapper.
`timescale 1ns/1ps
`default_nettype none
module tb_code_bank_mapper;
  import cbm_pkg::*;
  logic i_sys_clk = 1'h0, i_rst = 1'h1, i_small_variant = 1'h0;
  logic i_sfr_rd = 1'h0, i_sfr_wr = 1'h0, i_idata_req = 1'h0, i_idata_we = 1'h0;
  logic [7:0] i_sfr_addr = 8'h00, i_sfr_wdata = 8'h00, i_idata_addr = 8'h00, i_idata_wdata = 8'h00;
  wire logic i_fetch_req, i_code_rd_req, i_xmove_req, i_xmove_we;
  wire logic [15:0] i_fetch_addr, i_code_rd_addr, i_xmove_addr;
  wire logic [7:0] i_xmove_wdata;
  logic [7:0] o_sfr_rdata, o_const_wdata, o_xdata_wdata, o_idata_rdata;
  logic o_sfr_ack, o_fetch_valid, o_const_valid, o_const_we, o_xdata_valid, o_xdata_we;
  logic o_reserved_hit, o_idata_valid;
  logic [15:0] o_xdata_addr;
  cbm_phys_t o_fetch_phys, o_const_phys;
  cbm_kind_t o_last_kind;
  int mismatches = 0, num_checks = 0;
  always #50 i_sys_clk = ~i_sys_clk;
  cbm_core_model core (.i_sys_clk, .o_fetch_req(i_fetch_req), .o_fetch_addr(i_fetch_addr),
    .o_code_rd_req(i_code_rd_req), .o_code_rd_addr(i_code_rd_addr), .o_xmove_req(i_xmove_req),
    .o_xmove_we(i_xmove_we), .o_xmove_addr(i_xmove_addr), .o_xmove_wdata(i_xmove_wdata));
  cbm_mapper DUT (.i_sys_clk, .i_rst, .i_small_variant, .i_sfr_rd, .i_sfr_wr, .i_sfr_addr,
    .i_sfr_wdata, .o_sfr_rdata, .o_sfr_ack, .i_fetch_req, .i_fetch_addr, .o_fetch_valid,
    .o_fetch_phys, .i_code_rd_req, .i_code_rd_addr, .i_xmove_req, .i_xmove_we, .i_xmove_addr,
    .i_xmove_wdata, .o_const_valid, .o_const_we, .o_const_phys, .o_const_wdata, .o_xdata_valid,
    .o_xdata_we, .o_xdata_addr, .o_xdata_wdata, .o_reserved_hit, .o_last_kind, .i_idata_req,
    .i_idata_we, .i_idata_addr, .i_idata_wdata, .o_idata_rdata, .o_idata_valid);
  task automatic check(input logic [16:0] seen, input logic [16:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR at %0t ns: seen 0x%0h expected 0x%0h", $time, seen, exp);
    end
  endtask : check
  task automatic sfr(input logic rd, input logic [7:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    i_sfr_rd    <= rd;
    i_sfr_wr    <= ~rd;
    i_sfr_addr  <= a;
    i_sfr_wdata <= d;
    @(posedge i_sys_clk);
    i_sfr_rd    <= 1'h0;
    i_sfr_wr    <= 1'h0;
    i_sfr_addr  <= ~a;
    i_sfr_wdata <= ~d;
    #1;
  endtask : sfr
  task automatic t_regs;
    sfr(1'h1, 8'hB1, 8'h00); check(o_sfr_rdata, 17'h0_0000);
    sfr(1'h0, 8'hB1, 8'hFF); check(o_sfr_ack, 17'h0_0001);
    sfr(1'h1, 8'hB1, 8'h00); check(o_sfr_rdata, 17'h0_0033);
    sfr(1'h0, 8'hB2, 8'hFF);
    sfr(1'h1, 8'hB2, 8'h00); check(o_sfr_rdata, 17'h0_0001);
    sfr(1'h1, 8'hB3, 8'h00); check({o_sfr_ack, o_sfr_rdata}, 17'h0_0000);
    $display("test regs done");
  endtask : t_regs
  task automatic t_banks;
    // Fetch and constant fields get different codes so a swapped field shows up.
    for (int b = 0; b < 4; b++) begin
      sfr(1'h0, 8'hB1, {2'h0, 2'(3 - b), 2'h0, 2'(b)});
      core.fetch(16'h8123); check(o_fetch_phys, {2'(b), 15'h0123});
      check(o_fetch_valid, 17'h0_0001);
      core.fetch(16'h1234); check(o_fetch_phys, 17'h0_1234);
      core.code_rd(16'h8005); check(o_const_phys, {2'(3 - b), 15'h0005});
      check(o_const_valid, 17'h0_0001);
      check(o_last_kind, CBM_KIND_CONST_RD);
    end
    $display("test banks done");
  endtask : t_banks
  task automatic t_moves;
    sfr(1'h0, 8'hB1, 8'h30);
    core.xmove(1'h1, 16'h8000, 8'h5A); check(o_const_phys, 17'h1_8000);
    check(o_const_we, 17'h0_0001);
    check(o_last_kind, CBM_KIND_FLASH_WR);
    check(o_const_wdata, 17'h0_005A);
    core.xmove(1'h1, 16'hFC00, 8'h11); check({o_reserved_hit, o_const_we}, 17'h0_0002);
    sfr(1'h0, 8'hB2, 8'h00);
    core.xmove(1'h1, 16'h8000, 8'h22); check({o_xdata_we, o_const_valid}, 17'h0_0002);
    check(o_xdata_wdata, 17'h0_0022);
    core.xmove(1'h0, 16'h8004, 8'h00); check(o_xdata_addr, 17'h0_8004);
    $display("test moves done");
  endtask : t_moves
  task automatic t_idata;
    @(posedge i_sys_clk);
    i_idata_req   <= 1'h1;
    i_idata_we    <= 1'h1;
    i_idata_addr  <= 8'h10;
    i_idata_wdata <= 8'hA5;
    @(posedge i_sys_clk);
    i_idata_we    <= 1'h0;
    i_idata_wdata <= 8'h5A;
    @(posedge i_sys_clk);
    i_idata_req   <= 1'h0;
    #1;
    check({o_idata_valid, o_idata_rdata}, 17'h0_01A5);
    $display("test idata done");
  endtask : t_idata
  task automatic t_small;
    @(posedge i_sys_clk);
    i_small_variant <= 1'h1;
    repeat (3) @(posedge i_sys_clk);
    sfr(1'h0, 8'hB1, 8'h22);
    core.fetch(16'h8123); check(o_fetch_phys, 17'h0_8123);
    core.code_rd(16'hFC10); check(o_const_phys, 17'h0_FC10);
    check(o_reserved_hit, 17'h0_0000);
    $display("test small done");
  endtask : t_small
  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : finish_test
  initial begin
    #200000;
    mismatches++;
    finish_test;
  end
  initial begin
    repeat (16) @(posedge i_sys_clk);
    i_rst <= 1'h0;
    t_regs;
    t_banks;
    t_moves;
    t_idata;
    t_small;
    finish_test;
  end
endmodule : tb_code_bank_mapper
`default_nettype wire
